// ==== hw/crpr_defs.vh ====
// constants for the channel remap and shutdown priority register bank
// assumes one 200 MHz device clock and byte-wide register commands
`ifndef CRPR_DEFS_VH
`define CRPR_DEFS_VH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CRPR_CMD_REMAP      8'h26
`define CRPR_CMD_PRIO12     8'h27
`define CRPR_CMD_PRIO34     8'h28

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CRPR_REMAP_RST      8'he4
`define CRPR_PRIO_RST       8'h00

// ----------------------------------------------------------------
// field layout
// ----------------------------------------------------------------
`define CRPR_CODE_W         2
`define CRPR_LEVEL_W        3
`define CRPR_LO_LEVEL_LSB   0
`define CRPR_HI_LEVEL_LSB   4
`define CRPR_UNUSED_LO_BIT  3
`define CRPR_UNUSED_HI_BIT  7

// ----------------------------------------------------------------
// remap codes, one per physical channel
// ----------------------------------------------------------------
`define CRPR_PHYS_CH1       2'h0
`define CRPR_PHYS_CH2       2'h1
`define CRPR_PHYS_CH3       2'h2
`define CRPR_PHYS_CH4       2'h3

`endif

// ==== hw/crpr_route.v ====
// routes per-logical-channel requests to physical channels by remap code
// assumes the remap field holds four distinct 2-bit codes
`timescale 1ns/1ps
`include "crpr_defs.vh"

module crpr_route
#(
    parameter NCH = 4
)
(
    input  wire [2*NCH-1:0] i_remap,    // packed remap codes, logical 1 in low bits
    input  wire [NCH-1:0]   i_log_req,  // request per logical channel
    output wire [NCH-1:0]   o_phys_req  // request per physical channel
);

    // ----------------------------------------------------------------
    // one or-tree per physical channel
    // ----------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < NCH; p = p + 1)
        begin : g_phys
            // a genvar cannot be part-selected, so its code is taken from a copy
            localparam [31:0] PIDX = p;
            reg hit;
            integer l;
            always @*
            begin
                hit = 1'b0;
                for (l = 0; l < NCH; l = l + 1)
                begin
                    // code 00 is physical 1 up to code 11 for physical 4
                    if (i_log_req[l] &&
                        (i_remap[2*l +: `CRPR_CODE_W] == PIDX[`CRPR_CODE_W-1:0]))
                    begin
                        hit = 1'b1;
                    end
                end
            end
            assign o_phys_req[p] = hit;
        end
    endgenerate

endmodule

// ==== hw/crpr_regs.v ====
// remap and shutdown priority registers of one four-channel group
// assumes commands arrive decoded from the management bus, one per cycle,
// and that channel off flags come from the channel state machines
`timescale 1ns/1ps
`include "crpr_defs.vh"

// Summary of operation
// - remap codes 00..11 select physical channels 1..4
// - top bit pair maps logical 4, each lower pair the next lower one
// - remap writes with a repeated code are dropped; mapping kept
// - reset pin leaves the remap register untouched
// - command 27h: channel 2 level in bits 6:4, channel 1 in 2:0, reset 0
// - command 28h: channel 4 level in bits 6:4, channel 3 in 2:0, reset 0
// - remap accepted only while all four channels are off
// - remap default e4h maps each logical channel to itself
// - shutdown code turns off channels whose level is at least the code
module crpr_regs
#(
    parameter NCH = 4
)
(
    input  wire       i_clk,         // device clock, 200 MHz
    input  wire       i_nrst,        // reset pin, async, active low
    input  wire       i_npor,        // power-on reset, async, active low
    input  wire       i_reset_cmd,   // reset command pulse, restores remap
    input  wire       i_cmd_valid,   // register command strobe
    input  wire       i_cmd_write,   // 1 write, 0 read
    input  wire [7:0] i_cmd_code,    // command code
    input  wire [7:0] i_cmd_wdata,   // write data byte
    output reg  [7:0] o_rd_data,     // read data byte
    output reg        o_rd_valid,    // read answer pulse
    output reg        o_cmd_hit,     // last command matched a register
    input  wire [3:0] i_chan_off,    // channel in off mode, per channel
    input  wire       i_multilevel_priority_enable, // three-bit priority on
    input  wire       i_fast_shutdown_valid,        // shutdown code pulse
    input  wire [2:0] i_fast_shutdown_serial_input, // received shutdown code
    output reg  [3:0] o_shutdown_phys, // turn-off pulse per physical channel
    output reg  [3:0] o_shutdown_log,  // turn-off pulse per logical channel
    output wire [7:0] o_remap,         // current remap register
    output wire [7:0] o_prio12,        // current priority 1/2 register
    output wire [7:0] o_prio34         // current priority 3/4 register
);

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    reg  [7:0]     remap_q;
    reg  [7:0]     remap_d;
    reg  [7:0]     prio12_q;
    reg  [7:0]     prio34_q;
    wire           nrst_all;
    wire           wr_remap;
    wire           wr_prio12;
    wire           wr_prio34;
    wire           all_off;
    wire           codes_unique;
    wire [NCH-1:0] log_req;
    wire [NCH-1:0] phys_req;
    wire [2:0]     level [0:NCH-1];

    // pin reset and power-on both clear the priority bytes
    assign nrst_all = i_nrst & i_npor;

    assign wr_remap  = i_cmd_valid & i_cmd_write & (i_cmd_code == `CRPR_CMD_REMAP);
    assign wr_prio12 = i_cmd_valid & i_cmd_write & (i_cmd_code == `CRPR_CMD_PRIO12);
    assign wr_prio34 = i_cmd_valid & i_cmd_write & (i_cmd_code == `CRPR_CMD_PRIO34);

    // ----------------------------------------------------------------
    // remap validation
    // ----------------------------------------------------------------
    // every pair compared; a single repeat drops the whole byte
    function uniq4;
        input [7:0] v;
        begin
            uniq4 = (v[1:0] != v[3:2]) && (v[1:0] != v[5:4]) &&
                    (v[1:0] != v[7:6]) && (v[3:2] != v[5:4]) &&
                    (v[3:2] != v[7:6]) && (v[5:4] != v[7:6]);
        end
    endfunction

    assign codes_unique = uniq4(i_cmd_wdata);
    assign all_off      = &i_chan_off;

    always @*
    begin
        remap_d = remap_q;
        if (i_reset_cmd)
        begin
            remap_d = `CRPR_REMAP_RST;
        end
        else if (wr_remap && all_off && codes_unique)
        begin
            remap_d = i_cmd_wdata;
        end
    end

    // ----------------------------------------------------------------
    // remap register
    // ----------------------------------------------------------------
    // only power-on and the reset command clear it; the reset pin must keep host changes
    always @(posedge i_clk or negedge i_npor)
    begin
        if (!i_npor)
        begin
            remap_q <= `CRPR_REMAP_RST;
        end
        else
        begin
            remap_q <= remap_d;
        end
    end

    // ----------------------------------------------------------------
    // priority registers
    // ----------------------------------------------------------------
    // unused bits 7 and 3 are stored as written and read back, but no level field uses them
    always @(posedge i_clk or negedge nrst_all)
    begin
        if (!nrst_all)
        begin
            prio12_q <= `CRPR_PRIO_RST;
            prio34_q <= `CRPR_PRIO_RST;
        end
        else
        begin
            if (wr_prio12)
            begin
                prio12_q <= i_cmd_wdata;
            end
            if (wr_prio34)
            begin
                prio34_q <= i_cmd_wdata;
            end
        end
    end

    assign level[0] = prio12_q[`CRPR_LO_LEVEL_LSB +: `CRPR_LEVEL_W];
    assign level[1] = prio12_q[`CRPR_HI_LEVEL_LSB +: `CRPR_LEVEL_W];
    assign level[2] = prio34_q[`CRPR_LO_LEVEL_LSB +: `CRPR_LEVEL_W];
    assign level[3] = prio34_q[`CRPR_HI_LEVEL_LSB +: `CRPR_LEVEL_W];

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // unknown codes answer zero with hit low, so the bus side can nack
    always @(posedge i_clk or negedge nrst_all)
    begin
        if (!nrst_all)
        begin
            o_rd_data  <= 8'h00;
            o_rd_valid <= 1'b0;
            o_cmd_hit  <= 1'b0;
        end
        else
        begin
            o_rd_valid <= i_cmd_valid & ~i_cmd_write;
            if (i_cmd_valid)
            begin
                o_cmd_hit <= (i_cmd_code == `CRPR_CMD_REMAP) ||
                             (i_cmd_code == `CRPR_CMD_PRIO12) ||
                             (i_cmd_code == `CRPR_CMD_PRIO34);
            end
            if (i_cmd_valid && !i_cmd_write)
            begin
                case (i_cmd_code)
                    `CRPR_CMD_REMAP:  o_rd_data <= remap_q;
                    `CRPR_CMD_PRIO12: o_rd_data <= prio12_q;
                    `CRPR_CMD_PRIO34: o_rd_data <= prio34_q;
                    default:          o_rd_data <= 8'h00;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // fast shutdown by priority
    // ----------------------------------------------------------------
    genvar c;
    generate
        for (c = 0; c < NCH; c = c + 1)
        begin : g_cmp
            assign log_req[c] = i_multilevel_priority_enable & i_fast_shutdown_valid &
                                (level[c] >= i_fast_shutdown_serial_input);
        end
    endgenerate

    crpr_route
    #(
        .NCH        (NCH)
    )
    u_route
    (
        .i_remap    (remap_q),
        .i_log_req  (log_req),
        .o_phys_req (phys_req)
    );

    // pulses only; the channel logic keeps any running cool-down timer
    always @(posedge i_clk or negedge nrst_all)
    begin
        if (!nrst_all)
        begin
            o_shutdown_phys <= 4'h0;
            o_shutdown_log  <= 4'h0;
        end
        else
        begin
            o_shutdown_phys <= phys_req;
            o_shutdown_log  <= log_req;
        end
    end

    assign o_remap  = remap_q;
    assign o_prio12 = prio12_q;
    assign o_prio34 = prio34_q;

endmodule

// ==== testbench/crpr_regs_monitor.sv ====
// checker for the remap and priority register bank
// assumes binding onto crpr_regs, one clock domain
`timescale 1ns/1ps
module crpr_regs_monitor (
    input wire       i_clk,                        // clock
    input wire       i_nrst,                       // reset pin
    input wire       i_npor,                       // power-on reset
    input wire       i_reset_cmd,                  // reset command
    input wire       i_cmd_valid,                  // strobe
    input wire       i_cmd_write,                  // direction
    input wire [7:0] i_cmd_code,                   // command
    input wire [7:0] i_cmd_wdata,                  // write byte
    input wire [3:0] i_chan_off,                   // off flags
    input wire       i_multilevel_priority_enable, // priority on
    input wire       i_fast_shutdown_valid,        // shutdown strobe
    input wire       o_rd_valid,                   // read pulse
    input wire       o_cmd_hit,                    // code hit
    input wire [3:0] o_shutdown_log,               // turn-off pulses
    input wire [7:0] o_remap,                      // remap
    input wire [7:0] o_prio12,                     // priority 1/2
    input wire [7:0] o_prio34                      // priority 3/4
);
    wire rd = i_cmd_valid && !i_cmd_write;
    wire wr = i_cmd_valid && i_cmd_write;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst || !i_npor);
    chk_rd_pulse: assert property (rd |=> o_rd_valid && $past(rd))
        else $error("read answer missing");
    chk_rd_quiet: assert property (!rd |=> !o_rd_valid)
        else $error("read answer without read");
    chk_prio12_wr: assert property (
        wr && i_cmd_code == 8'h27 |=> o_prio12 == $past(i_cmd_wdata))
        else $error("priority 1/2 write lost");
    chk_prio34_wr: assert property (
        wr && i_cmd_code == 8'h28 |=> o_prio34 == $past(i_cmd_wdata))
        else $error("priority 3/4 write lost");
    chk_prio_hold: assert property (!(wr && i_cmd_code == 8'h27) |=> $stable(o_prio12))
        else $error("priority 1/2 changed unasked");
    chk_remap_busy: assert property (
        wr && i_cmd_code == 8'h26 && i_chan_off != 4'hf && !i_reset_cmd |=> $stable(o_remap))
        else $error("remap taken while a channel is on");
    chk_remap_restore: assert property (i_reset_cmd |=> o_remap == 8'he4)
        else $error("reset command did not restore remap");
    chk_hit_known: assert property (
        i_cmd_valid && i_cmd_code inside {8'h26, 8'h27, 8'h28} |=> o_cmd_hit)
        else $error("known code not hit");
    chk_shut_gate: assert property (
        !(i_fast_shutdown_valid && i_multilevel_priority_enable) |=> o_shutdown_log == 4'h0)
        else $error("turn-off pulse without enabled code");
endmodule

bind crpr_regs crpr_regs_monitor crpr_regs_monitor_i (.i_clk, .i_nrst, .i_npor,
    .i_reset_cmd, .i_cmd_valid, .i_cmd_write, .i_cmd_code, .i_cmd_wdata, .i_chan_off,
    .i_multilevel_priority_enable, .i_fast_shutdown_valid, .o_rd_valid, .o_cmd_hit,
    .o_shutdown_log, .o_remap, .o_prio12, .o_prio34);

// ==== testbench/crpr_host.sv ====
// host model issuing byte commands to the register bank
// assumes calls start after reset release
`timescale 1ns/1ps
module crpr_host (
    input  wire       i_clk,     // clock
    input  wire [7:0] i_rd_data, // read byte
    output reg        o_valid,   // strobe
    output reg        o_write,   // direction
    output reg  [7:0] o_code,    // command
    output reg  [7:0] o_wdata    // write byte
);
    initial
    begin
        o_valid = 1'b0;
        o_write = 1'b0;
        o_code  = 8'h00;
        o_wdata = 8'h00;
    end
    // one idle edge between commands so the strobe never flips twice at once
    task xfer(input bit w, input [7:0] c, input [7:0] d, output [7:0] r);
        @(posedge i_clk);
        #1;
        {o_valid, o_write, o_code, o_wdata} = {1'b1, w, c, d};
        @(posedge i_clk);
        #1;
        r = i_rd_data;
        // released lines show inverted data, not the old value
        {o_valid, o_code, o_wdata} = {1'b0, ~c, ~d};
    endtask
endmodule

// ==== testbench/tb_top.sv ====
// self-checking bench for crpr_regs against an integer model
// assumes host model and checker compiled first
`timescale 1ns/1ps
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", n, e, a); end end
module tb_top;
    reg        i_clk = 0, i_nrst = 0, i_npor = 0, rcmd = 0, en = 0, fsv = 0;
    reg  [3:0] off = 4'hf;
    reg  [2:0] fsc = 0;
    wire       v, w, rv, hit;
    wire [7:0] c, d, rd, rm, p12, p34;
    wire [3:0] sp, sl;
    reg  [7:0] m_rm, m_p [2], r, x;
    reg  [3:0] xl, xp;
    int        miscompares = 0, compares = 0, k, j, lv;
    always #2.5 i_clk = ~i_clk;
    crpr_host crpr_host_i (.i_clk(i_clk), .i_rd_data(rd), .o_valid(v), .o_write(w),
        .o_code(c), .o_wdata(d));
    crpr_regs crpr_regs_i (.i_clk(i_clk), .i_nrst(i_nrst), .i_npor(i_npor),
        .i_reset_cmd(rcmd), .i_cmd_valid(v), .i_cmd_write(w), .i_cmd_code(c),
        .i_cmd_wdata(d), .o_rd_data(rd), .o_rd_valid(rv), .o_cmd_hit(hit),
        .i_chan_off(off), .i_multilevel_priority_enable(en),
        .i_fast_shutdown_valid(fsv), .i_fast_shutdown_serial_input(fsc),
        .o_shutdown_phys(sp), .o_shutdown_log(sl), .o_remap(rm), .o_prio12(p12),
        .o_prio34(p34));
    function bit uniq(input [7:0] u);
        uniq = u[1:0] != u[3:2] && u[1:0] != u[5:4] && u[1:0] != u[7:6]
            && u[3:2] != u[5:4] && u[3:2] != u[7:6] && u[5:4] != u[7:6];
    endfunction
    task rdchk(input [7:0] a, input [7:0] e);
        crpr_host_i.xfer(1'b0, a, 8'h00, r);
        `CHK("read", e, r)
        `CHK("rvalid", 1'b1, rv)
        `CHK("hit", a inside {8'h26, 8'h27, 8'h28}, hit)
    endtask
    task shut(input [2:0] s);
        @(posedge i_clk);
        #1;
        {fsv, fsc} = {1'b1, s};
        @(posedge i_clk);
        #1;
        fsv = 1'b0;
        {xl, xp} = 8'h00;
        for (j = 0; j < 4; j++)
        begin
            lv = (m_p[j / 2] >> (4 * (j % 2))) & 7;
            if (en && lv >= s)
                {xl[j], xp[m_rm[2 * j +: 2]]} = 2'b11;
        end
        `CHK("shut_log", xl, sl)
        `CHK("shut_phys", xp, sp)
    endtask
    task conclude;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #20000;
        miscompares++;
        conclude;
    end
    initial
    begin
        void'($urandom(32'h313304da));
        repeat (16) @(posedge i_clk);
        #1;
        {i_nrst, i_npor} = 2'b11;
        {m_rm, m_p[0], m_p[1]} = {8'he4, 16'h0000};
        rdchk(8'h26, m_rm);
        rdchk(8'h27, 8'h00);
        rdchk(8'h28, 8'h00);
        rdchk(8'h29, 8'h00);
        $display("reset values done");
        for (k = 0; k < 8; k++)
        begin
            x = $urandom;
            crpr_host_i.xfer(1'b1, 8'h27 + k % 2, x, r);
            m_p[k % 2] = x;
            rdchk(8'h27 + k % 2, x);
            `CHK("prio_out", x, k[0] ? p34 : p12)
        end
        $display("priority writes done");
        for (k = 0; k < 24; k++)
        begin
            x = k[0] ? $urandom : {m_rm[1:0], m_rm[7:2]};
            off = ($urandom % 3) ? 4'hf : $urandom;
            // channels all off for about two of three remap writes, random off flags otherwise; even writes rotate the current mapping by one pair
            crpr_host_i.xfer(1'b1, 8'h26, x, r);
            if (off == 4'hf && uniq(x))
                m_rm = x;
            rdchk(8'h26, m_rm);
            `CHK("remap_out", m_rm, rm)
            en = $urandom;
            shut($urandom);
        end
        $display("remap and shutdown done");
        @(posedge i_clk);
        #1;
        i_nrst = 1'b0;
        @(posedge i_clk);
        #1;
        i_nrst = 1'b1;
        {m_p[0], m_p[1]} = 16'h0000;
        rdchk(8'h26, m_rm);
        rdchk(8'h28, 8'h00);
        @(posedge i_clk);
        #1;
        rcmd = 1'b1;
        @(posedge i_clk);
        #1;
        rcmd = 1'b0;
        m_rm = 8'he4;
        rdchk(8'h26, m_rm);
        `CHK("remap_out", m_rm, rm)
        $display("reset paths done");
        conclude;
    end
endmodule
